/* qbs_pkg.sv */
// constants, types and helpers shared by the burst sram port
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
package qbs_pkg;

	// ----------------------------------------------------------------
	// widths: the 18-bit variant
	// ----------------------------------------------------------------
	localparam int DW = 18;
	localparam int AW = 18;
	localparam int LANES = 2;
	localparam int LW = 9;
	localparam int MW = 2 * DW;
	localparam int MLANES = 2 * LANES;
	localparam int MAW = AW + 1;
	localparam int FIFO_DEPTH = 8;
	localparam logic [1:0] SYNC_RST = 2'h0;
	localparam logic [MW-1:0] PAIR_RST = 36'h0;
	localparam logic [DW-1:0] BEAT_RST = 18'h0;
	localparam logic [AW-1:0] ADDR_RST = 18'h0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef logic [MW-1:0] qbs_pair_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [AW-1:0] waddr;
		logic whalf;
		qbs_pair_t wdata;
		logic [MLANES-1:0] wlane;
		logic [AW-1:0] raddr;
	} qbs_req_t;

	localparam int REQ_W = $bits(qbs_req_t);

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_EXEC = 5'h02,
		ST_RD = 5'h04,
		ST_WAIT = 5'h08,
		ST_PUSH = 5'h10
	} qbs_state_t;

	typedef struct packed {
		logic wr_pend;
		logic wr_busy;
		logic whalf;
		logic [AW-1:0] waddr;
		logic [DW-1:0] beat_pos;
		logic [LANES-1:0] lane_pos;
		logic rd_pend;
		logic rd_busy;
		logic [AW-1:0] raddr;
		logic overrun;
	} qbs_link_t;

	typedef struct packed {
		qbs_state_t st;
		qbs_req_t req;
		logic half;
		qbs_pair_t rdata;
	} qbs_core_t;

	typedef struct packed {
		logic oe;
		qbs_pair_t pair;
	} qbs_out_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [LANES-1:0] lane_en(input logic [LANES-1:0] m_n);
		return ~m_n;
	endfunction

endpackage

/* qbs_fifo.sv */
// dual clock fifo with gray coded pointers
`timescale 1ns/100ps
module qbs_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic wclk,
	input wire logic wrst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	input wire logic rclk,
	input wire logic rrst_n,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	function automatic logic [PW:0] to_gray(input logic [PW:0] b);
		return b ^ (b >> 1);
	endfunction

	logic [W-1:0] mem [DEPTH];
	logic [PW:0] wbin_q, wgray_q, rg_s1_q, rg_s2_q;
	logic [PW:0] rbin_q, rgray_q, wg_s1_q, wg_s2_q;
	logic [PW:0] wbin_d, rbin_d;
	logic push, pop;

	// ----------------------------------------------------------------
	// write side
	// ----------------------------------------------------------------
	assign in_ready = wgray_q !=
		{~rg_s2_q[PW:PW-1], rg_s2_q[PW-2:0]};
	assign push = in_valid & in_ready;
	assign wbin_d = push ? wbin_q + 1'b1 : wbin_q;

	always_ff @(posedge wclk) begin
		if (push) begin
			mem[wbin_q[PW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge wclk or negedge wrst_n) begin
		if (!wrst_n) begin
			wbin_q <= '0;
			wgray_q <= '0;
			rg_s1_q <= '0;
			rg_s2_q <= '0;
		end else begin
			wbin_q <= wbin_d;
			wgray_q <= to_gray(wbin_d);
			rg_s1_q <= rgray_q;
			rg_s2_q <= rg_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// read side
	// ----------------------------------------------------------------
	assign out_valid = rgray_q != wg_s2_q;
	assign pop = out_valid & out_ready;
	assign rbin_d = pop ? rbin_q + 1'b1 : rbin_q;
	assign out_data = mem[rbin_q[PW-1:0]];

	always_ff @(posedge rclk or negedge rrst_n) begin
		if (!rrst_n) begin
			rbin_q <= '0;
			rgray_q <= '0;
			wg_s1_q <= '0;
			wg_s2_q <= '0;
		end else begin
			rbin_q <= rbin_d;
			rgray_q <= to_gray(rbin_d);
			wg_s1_q <= wgray_q;
			wg_s2_q <= wg_s1_q;
		end
	end

endmodule

/* qbs_mem.sv */
// storage array with per-lane write enables and registered read
`timescale 1ns/100ps
module qbs_mem (
	input wire logic clk,
	input wire logic we,
	input wire logic [qbs_pkg::MLANES-1:0] lane_we,
	input wire logic [qbs_pkg::MAW-1:0] addr,
	input wire logic [qbs_pkg::MW-1:0] wdata,
	output logic [qbs_pkg::MW-1:0] rdata
);
	import qbs_pkg::*;

	logic [MW-1:0] arr [2**MAW];

	always_ff @(posedge clk) begin
		for (int i = 0; i < MLANES; i++) begin
			if (we && lane_we[i]) begin
				arr[addr][i*LW +: LW] <= wdata[i*LW +: LW];
			end
		end
		rdata <= arr[addr];
	end

endmodule

/* qbs_port.sv */
// burst-of-four sram bus port: link capture, core and read launch
`timescale 1ns/100ps
module qbs_port (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic k_clk,
	input wire logic c_clk,
	input wire logic single_clk_mode,
	input wire logic write_port_sel_n,
	input wire logic read_port_sel_n,
	input wire logic [qbs_pkg::AW-1:0] addr,
	input wire logic [qbs_pkg::DW-1:0] wdata,
	input wire logic lane_mask0_n,
	input wire logic lane_mask1_n,
	output logic [qbs_pkg::DW-1:0] rdata_o,
	output logic rdata_oe,
	output logic link_ready,
	output logic link_overrun
);
	import qbs_pkg::*;

	// ----------------------------------------------------------------
	// clocks and resets
	// ----------------------------------------------------------------
	logic launch_clk;
	logic [1:0] core_rst_q, k_rst_q, o_rst_q;
	logic core_rst_n, k_rst_n, o_rst_n;

	// read beats go out on C, or on K in single clock mode
	assign launch_clk = single_clk_mode ? k_clk : c_clk;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			core_rst_q <= SYNC_RST;
		end else begin
			core_rst_q <= {core_rst_q[0], 1'b1};
		end
	end

	always_ff @(posedge k_clk or negedge rst_n) begin
		if (!rst_n) begin
			k_rst_q <= SYNC_RST;
		end else begin
			k_rst_q <= {k_rst_q[0], 1'b1};
		end
	end

	always_ff @(posedge launch_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rst_q <= SYNC_RST;
		end else begin
			o_rst_q <= {o_rst_q[0], 1'b1};
		end
	end

	assign core_rst_n = core_rst_q[1];
	assign k_rst_n = k_rst_q[1];
	assign o_rst_n = o_rst_q[1];

	// ----------------------------------------------------------------
	// link side: capture on K rise and K-bar rise
	// ----------------------------------------------------------------
	qbs_link_t l_q, l_d;
	logic [DW-1:0] beat_neg_q;
	logic [LANES-1:0] lane_neg_q;
	logic [LANES-1:0] mask_n;
	qbs_req_t wq_in;
	logic wq_valid_in, wq_ready_in;

	// this variant gates 9-bit lanes, nibble selects are not present
	assign mask_n = {lane_mask1_n, lane_mask0_n};

	// odd beats with their own lane selects on the K-bar edge
	always_ff @(negedge k_clk or negedge k_rst_n) begin
		if (!k_rst_n) begin
			beat_neg_q <= BEAT_RST;
			lane_neg_q <= '0;
		end else begin
			beat_neg_q <= wdata;
			lane_neg_q <= lane_en(mask_n);
		end
	end

	always_comb begin
		l_d = l_q;
		l_d.wr_pend = 1'b0;
		l_d.rd_pend = 1'b0;
		// write port, sampled only here on the K rise
		if (l_q.wr_busy) begin
			l_d.wr_pend = 1'b1;
			l_d.whalf = 1'b1;
			l_d.beat_pos = wdata;
			l_d.lane_pos = lane_en(mask_n);
			l_d.wr_busy = 1'b0;
		end else if (!write_port_sel_n) begin
			l_d.wr_pend = 1'b1;
			l_d.wr_busy = 1'b1;
			l_d.whalf = 1'b0;
			l_d.waddr = addr;
			l_d.beat_pos = wdata;
			l_d.lane_pos = lane_en(mask_n);
		end
		// a high write select leaves data and address unread, except at a burst's second K rise, where data is taken
		// read port, with its request timing set by the write port's select and busy state
		// a read taken with a starting write rides with its second pair
		if (l_q.rd_busy) begin
			l_d.rd_pend = ~l_q.rd_pend;
			l_d.rd_busy = 1'b0;
		end else if (!read_port_sel_n) begin
			l_d.rd_pend = l_q.wr_busy | write_port_sel_n;
			l_d.rd_busy = 1'b1;
			l_d.raddr = addr;
		end
		if (wq_valid_in && !wq_ready_in) begin
			l_d.overrun = 1'b1;
		end
	end

	always_ff @(posedge k_clk or negedge k_rst_n) begin
		if (!k_rst_n) begin
			l_q <= '{wr_pend: 1'b0, wr_busy: 1'b0, whalf: 1'b0,
				waddr: ADDR_RST, beat_pos: BEAT_RST, lane_pos: '0,
				rd_pend: 1'b0, rd_busy: 1'b0, raddr: ADDR_RST,
				overrun: 1'b0};
		end else begin
			l_q <= l_d;
		end
	end

	// one request word carries a beat pair and/or a read address
	always_comb begin
		wq_in.wr = l_q.wr_pend;
		wq_in.rd = l_q.rd_pend;
		wq_in.waddr = l_q.waddr;
		wq_in.whalf = l_q.whalf;
		wq_in.wdata = {beat_neg_q, l_q.beat_pos};
		wq_in.wlane = {lane_neg_q, l_q.lane_pos};
		wq_in.raddr = l_q.raddr;
	end

	assign wq_valid_in = l_q.wr_pend | l_q.rd_pend;
	assign link_ready = wq_ready_in;
	assign link_overrun = l_q.overrun;

	// ----------------------------------------------------------------
	// request crossing into the core clock
	// ----------------------------------------------------------------
	logic [REQ_W-1:0] wq_out_bits;
	qbs_req_t wq_out;
	logic wq_valid_out, wq_pop;

	qbs_fifo #(.W(REQ_W), .DEPTH(FIFO_DEPTH)) u_req_fifo (
		.wclk(k_clk),
		.wrst_n(k_rst_n),
		.in_valid(wq_valid_in),
		.in_ready(wq_ready_in),
		.in_data(wq_in),
		.rclk(clock),
		.rrst_n(core_rst_n),
		.out_valid(wq_valid_out),
		.out_ready(wq_pop),
		.out_data(wq_out_bits)
	);

	assign wq_out = qbs_req_t'(wq_out_bits);

	// ----------------------------------------------------------------
	// core: array access
	// ----------------------------------------------------------------
	qbs_core_t c_q, c_d;
	logic mem_we;
	logic [MLANES-1:0] mem_lane;
	logic [MAW-1:0] mem_addr;
	qbs_pair_t mem_rdata;
	logic rq_push, rq_ready;
	qbs_pair_t rq_data;

	qbs_mem u_mem (
		.clk(clock),
		.we(mem_we),
		.lane_we(mem_lane),
		.addr(mem_addr),
		.wdata(c_q.req.wdata),
		.rdata(mem_rdata)
	);

	always_comb begin
		c_d = c_q;
		wq_pop = 1'b0;
		mem_we = 1'b0;
		mem_lane = '0;
		mem_addr = {c_q.req.raddr, c_q.half};
		rq_push = 1'b0;
		rq_data = c_q.rdata;
		case (c_q.st)
		ST_IDLE: begin
			wq_pop = 1'b1;
			if (wq_valid_out) begin
				c_d.req = wq_out;
				c_d.st = ST_EXEC;
			end
		end
		ST_EXEC: begin
			if (c_q.req.wr) begin
				mem_we = 1'b1;
				mem_lane = c_q.req.wlane;
				mem_addr = {c_q.req.waddr, c_q.req.whalf};
			end
			if (c_q.req.rd) begin
				c_d.half = 1'b0;
				c_d.st = ST_RD;
			end else begin
				c_d.st = ST_IDLE;
			end
		end
		ST_RD: begin
			c_d.st = ST_WAIT;
		end
		ST_WAIT: begin
			c_d.rdata = mem_rdata;
			rq_data = mem_rdata;
			rq_push = 1'b1;
			if (!rq_ready) begin
				c_d.st = ST_PUSH;
			end else if (!c_q.half) begin
				c_d.half = 1'b1;
				c_d.st = ST_RD;
			end else begin
				c_d.st = ST_IDLE;
			end
		end
		ST_PUSH: begin
			rq_push = 1'b1;
			if (rq_ready) begin
				if (!c_q.half) begin
					c_d.half = 1'b1;
					c_d.st = ST_RD;
				end else begin
					c_d.st = ST_IDLE;
				end
			end
		end
		default: begin
			c_d.st = ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge clock or negedge core_rst_n) begin
		if (!core_rst_n) begin
			c_q <= '{st: ST_IDLE, req: '0, half: 1'b0,
				rdata: PAIR_RST};
		end else begin
			c_q <= c_d;
		end
	end

	// ----------------------------------------------------------------
	// read data crossing into the launch clock
	// ----------------------------------------------------------------
	qbs_pair_t rq_out;
	logic rq_valid_out;

	qbs_fifo #(.W(MW), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
		.wclk(clock),
		.wrst_n(core_rst_n),
		.in_valid(rq_push),
		.in_ready(rq_ready),
		.in_data(rq_data),
		.rclk(launch_clk),
		.rrst_n(o_rst_n),
		.out_valid(rq_valid_out),
		.out_ready(1'b1),
		.out_data(rq_out)
	);

	// ----------------------------------------------------------------
	// read launch: even beat on the rise, odd beat on the fall
	// ----------------------------------------------------------------
	qbs_out_t o_q, o_d;
	logic [DW-1:0] odd_q;
	qbs_pair_t hold_q;
	logic hold_v_q, second_q, launch;

	// a burst goes out only with both pairs on hand, beats back to back
	always_comb begin
		o_d = o_q;
		launch = second_q | (hold_v_q & rq_valid_out);
		// with nothing left, drivers release after this rising edge
		o_d.oe = launch;
		if (launch) begin
			o_d.pair = hold_q;
		end
	end

	always_ff @(posedge launch_clk or negedge o_rst_n) begin
		if (!o_rst_n) begin
			o_q <= '{oe: 1'b0, pair: PAIR_RST};
			hold_q <= PAIR_RST;
			hold_v_q <= 1'b0;
			second_q <= 1'b0;
		end else begin
			o_q <= o_d;
			if (rq_valid_out) begin
				hold_q <= rq_out;
			end
			hold_v_q <= rq_valid_out | (hold_v_q & ~launch);
			second_q <= ~second_q & hold_v_q & rq_valid_out;
		end
	end

	always_ff @(negedge launch_clk or negedge o_rst_n) begin
		if (!o_rst_n) begin
			odd_q <= BEAT_RST;
		end else begin
			odd_q <= o_q.pair[MW-1:DW];
		end
	end

	assign rdata_o = launch_clk ? o_q.pair[DW-1:0] : odd_q;
	assign rdata_oe = o_q.oe;

endmodule

/* qbs_port_monitor.sv */
// assertion checker bound to the burst sram port
`timescale 1ns/100ps
module qbs_port_chk (
	input wire logic rst_n,
	input wire logic k_clk,
	input wire logic c_clk,
	input wire logic single_clk_mode,
	input wire logic write_port_sel_n,
	input wire logic read_port_sel_n,
	input wire logic rdata_oe,
	input wire logic link_ready,
	input wire logic link_overrun
);
	logic [5:0] idle_q;

	// ----------------------------------------------------------------
	// k cycles since the last read select
	// ----------------------------------------------------------------
	always_ff @(posedge k_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_q <= 6'h0;
		end else if (!read_port_sel_n) begin
			idle_q <= 6'h0;
		end else if (idle_q != 6'h3f) begin
			idle_q <= idle_q + 6'h1;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_burst_c;
		@(posedge c_clk) disable iff (!rst_n)
		!single_clk_mode && $rose(rdata_oe) |=> rdata_oe;
	endproperty
	a_burst_c: assert property (p_burst_c)
		else $error("read burst cut short on c");

	property p_burst_k;
		@(posedge k_clk) disable iff (!rst_n)
		single_clk_mode && $rose(rdata_oe) |=> rdata_oe;
	endproperty
	a_burst_k: assert property (p_burst_k)
		else $error("read burst cut short on k");

	property p_idle_off;
		@(posedge k_clk) disable iff (!rst_n)
		idle_q == 6'h3f |-> !rdata_oe;
	endproperty
	a_idle_off: assert property (p_idle_off)
		else $error("read outputs driven while idle");

	property p_drain_off;
		@(posedge c_clk) disable iff (!rst_n)
		!single_clk_mode && idle_q >= 6'h30 |-> !rdata_oe;
	endproperty
	a_drain_off: assert property (p_drain_off)
		else $error("read outputs not released");

	property p_rd_answer;
		@(posedge k_clk) disable iff (!rst_n)
		!read_port_sel_n && link_ready |-> ##[1:60] rdata_oe;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read select got no data");

	property p_ovr_cause;
		@(posedge k_clk) disable iff (!rst_n)
		$rose(link_overrun) |-> !$past(link_ready);
	endproperty
	a_ovr_cause: assert property (p_ovr_cause)
		else $error("overrun while buffer had room");

	property p_ovr_hold;
		@(posedge k_clk) disable iff (!rst_n)
		link_overrun |=> link_overrun;
	endproperty
	a_ovr_hold: assert property (p_ovr_hold)
		else $error("overrun flag dropped");

	property p_quiet;
		@(posedge k_clk) disable iff (!rst_n)
		$past(write_port_sel_n) && $past(write_port_sel_n, 2)
			&& $past(read_port_sel_n) && $past(read_port_sel_n, 2)
			&& link_ready |=> link_ready;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("buffer filled without a request");
endmodule

bind qbs_port qbs_port_chk chk (.rst_n, .k_clk, .c_clk, .single_clk_mode,
	.write_port_sel_n, .read_port_sel_n, .rdata_oe, .link_ready,
	.link_overrun);

/* qbs_ctrl_model.sv */
// memory controller model on the link side of the sram port
`timescale 1ns/100ps
module qbs_ctrl_model (
	output logic k_clk,
	output logic c_clk,
	output logic write_port_sel_n,
	output logic read_port_sel_n,
	output logic [qbs_pkg::AW-1:0] addr,
	output logic [qbs_pkg::DW-1:0] wdata,
	output logic lane_mask0_n,
	output logic lane_mask1_n,
	input wire logic single_clk_mode,
	input wire logic [qbs_pkg::DW-1:0] rdata_o,
	input wire logic rdata_oe
);
	import qbs_pkg::*;
	logic [DW-1:0] rq[$];
	wire logic launch_clk;
	assign launch_clk = single_clk_mode ? k_clk : c_clk;

	initial begin
		k_clk = 1'b0;
		c_clk = 1'b0;
		{write_port_sel_n, read_port_sel_n} = 2'h3;
		{lane_mask1_n, lane_mask0_n} = 2'h3;
		addr = 18'h0;
		wdata = 18'h0;
		forever #3 k_clk = ~k_clk;
	end

	always @(k_clk) c_clk <= #1 k_clk;

	// one burst: selects, address and beat 0 stand at one k rise,
	// the other three beats at the next three k edges
	task automatic xfer(input logic w, input logic r,
		input logic [AW-1:0] a, input logic [3:0][DW-1:0] d,
		input logic [7:0] m);
		@(posedge k_clk);
		write_port_sel_n <= ~w;
		read_port_sel_n <= ~r;
		addr <= a;
		wdata <= d[0];
		{lane_mask1_n, lane_mask0_n} <= m[1:0];
		@(posedge k_clk);
		{write_port_sel_n, read_port_sel_n} <= 2'h3;
		addr <= ~a;
		wdata <= d[1];
		{lane_mask1_n, lane_mask0_n} <= m[3:2];
		@(negedge k_clk);
		wdata <= d[2];
		{lane_mask1_n, lane_mask0_n} <= m[5:4];
		@(posedge k_clk);
		wdata <= d[3];
		{lane_mask1_n, lane_mask0_n} <= m[7:6];
	endtask

	// collect read beats mid phase of the launch clock
	always @(launch_clk) begin
		#1.5;
		if (rdata_oe === 1'b1) rq.push_back(rdata_o);
	end
endmodule

/* test_quad_rate_burst4_sram_port.sv */
// self-checking bench for the burst sram port
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_quad_rate_burst4_sram_port;
	import qbs_pkg::*;
	typedef struct packed {
		logic [AW-1:0] a;
		logic [3:0][DW-1:0] d;
		logic [7:0] m;
		logic [3:0][DW-1:0] e;
	} qbs_row_t;
	qbs_row_t rows [3];
	logic clock, rst_n, single_clk_mode, k_clk, c_clk, write_port_sel_n;
	logic read_port_sel_n, lane_mask0_n, lane_mask1_n, rdata_oe;
	logic link_ready, link_overrun;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata_o;
	logic run = 1'b1;
	int errors = 0;
	int check_count = 0;

	qbs_port dut (.clock, .rst_n, .k_clk, .c_clk, .single_clk_mode,
		.write_port_sel_n, .read_port_sel_n, .addr, .wdata, .lane_mask0_n,
		.lane_mask1_n, .rdata_o, .rdata_oe, .link_ready, .link_overrun);
	qbs_ctrl_model ctl (.k_clk, .c_clk, .write_port_sel_n,
		.read_port_sel_n, .addr, .wdata, .lane_mask0_n, .lane_mask1_n,
		.single_clk_mode, .rdata_o, .rdata_oe);

	initial begin
		clock = 1'b0;
		forever begin
			#5;
			if (run) clock = ~clock;
		end
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// wait for four read beats and compare them in order
	task automatic get(input logic [3:0][DW-1:0] e);
		logic [DW-1:0] v;
		for (int i = 0; i < 300 && ctl.rq.size() < 4; i++) @(posedge k_clk);
		if (ctl.rq.size() < 4) begin
			errors++;
			give_verdict();
		end else begin
			for (int i = 0; i < 4; i++) begin
				v = ctl.rq.pop_front();
				`CHK(v, e[i])
			end
		end
	endtask

	task automatic reset_to(input logic mode);
		@(posedge clock);
		rst_n <= 1'b0;
		single_clk_mode <= mode;
		repeat (4) @(posedge clock);
		`CHK(rdata_oe, 1'b0)
		`CHK({link_ready, link_overrun}, 2'h2)
		rst_n <= 1'b1;
		repeat (10) @(posedge clock);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		single_clk_mode = 1'b0;
		rows[0] = '{18'h0, {18'h3c3c3, 18'h01f0f, 18'h2abcd, 18'h12345},
			8'h0, {18'h3c3c3, 18'h01f0f, 18'h2abcd, 18'h12345}};
		rows[1] = '{18'h3ffff, {4{18'h0}}, 8'h39,
			{18'h0, 18'h3ffff, 18'h3fe00, 18'h001ff}};
		rows[2] = '{18'h15555, {4{18'h0aaaa}}, 8'h93,
			{18'h3feaa, 18'h0abff, 18'h0aaaa, 18'h3ffff}};
		reset_to(1'b0);
		foreach (rows[i]) begin
			ctl.xfer(1'b1, 1'b0, rows[i].a, {4{18'h3ffff}}, 8'h0);
			ctl.xfer(1'b1, 1'b0, rows[i].a, rows[i].d, rows[i].m);
			ctl.xfer(1'b0, 1'b1, rows[i].a, {4{18'h0}}, 8'h0);
			get(rows[i].e);
		end
		ctl.xfer(1'b0, 1'b0, rows[0].a, {4{18'h0}}, 8'h0);
		ctl.xfer(1'b0, 1'b1, rows[0].a, {4{18'h0}}, 8'h0);
		get(rows[0].e);
		ctl.xfer(1'b1, 1'b1, rows[1].a, rows[0].d, 8'h0);
		ctl.xfer(1'b0, 1'b1, rows[2].a, {4{18'h0}}, 8'h0);
		get(rows[0].d);
		get(rows[2].e);
		reset_to(1'b1);
		ctl.xfer(1'b1, 1'b0, 18'h00123, rows[0].d, 8'h0);
		ctl.xfer(1'b0, 1'b1, 18'h00123, {4{18'h0}}, 8'h0);
		get(rows[0].d);
		run = 1'b0;
		repeat (10) ctl.xfer(1'b1, 1'b0, 18'h00200, {4{18'h0}}, 8'h0);
		`CHK({link_ready, link_overrun}, 2'h1)
		give_verdict();
	end
endmodule
